// *** core/dsid_regs.svh ***
// timing counts, field positions and fixed codes of the instruction decoder
`ifndef DSID_REGS_SVH
`define DSID_REGS_SVH
`define DSID_WORD_W        24
`define DSID_OPC_W         8
`define DSID_OPC_MSB       23
`define DSID_OPC_LSB       16
`define DSID_SECOND_OPC    8'h00
`define DSID_CYC_ONE       2'h1
`define DSID_CYC_TWO       2'h2
`define DSID_CYC_THREE     2'h3
`define DSID_BLANK_ONE     2'h1
`define DSID_BLANK_TWO     2'h2
`define DSID_LIT_BYTE_MAX  10'h0FF
`define DSID_WB_STEP       16'h0002
`endif

// *** core/dsid_pkg.sv ***
// types shared by the instruction decoder files
`default_nettype none
package dsid_pkg;
  // coarse instruction class presented by the fetch side
  typedef enum logic [3:0] {
    DSID_CLS_PLAIN   = 4'h0,
    DSID_CLS_DOUBLE  = 4'h1,
    DSID_CLS_BRANCH  = 4'h2,
    DSID_CLS_LONGSW  = 4'h3,
    DSID_CLS_SKIP    = 4'h4,
    DSID_CLS_ADDACC  = 4'h5,
    DSID_CLS_ADD_WITH_CARRY_OP    = 4'h6,
    DSID_CLS_MAC     = 4'h7,
    DSID_CLS_FILEREG = 4'h8,
    DSID_CLS_BIT     = 4'h9,
    DSID_CLS_LIT     = 4'hA
  } dsid_cls_e;

  typedef enum logic [2:0] {
    DSID_ST_RUN  = 3'b001,
    DSID_ST_SEC  = 3'b010,
    DSID_ST_NOP  = 3'b100
  } dsid_state_e;

  // decoded operand fields
  typedef struct packed {
    logic [7:0] opcode;
    logic [3:0] base_reg_field;
    logic [3:0] source_reg_field;
    logic [3:0] dest_reg_field;
    logic [3:0] bit_select_field;
    logic [9:0] literal_ten_field;
    logic       lit_ok;
    logic       file_to_default_work_reg;
  } dsid_ops_s;

  // dsp operand fields
  typedef struct packed {
    logic       acc_sel;
    logic       pair_ok;
    logic [3:0] mul_a;
    logic [3:0] mul_b;
    logic [3:0] x_prefetch_addr;
    logic [1:0] x_dest;
    logic [3:0] y_prefetch_addr;
    logic [1:0] y_dest;
    logic [1:0] acc_writeback_dest;
  } dsid_dsp_s;

  // status flag image
  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic negative;
    logic overflow_flag;
    logic zero;
    logic acc_a_overflow_flag;
    logic acc_b_overflow_flag;
    logic acc_a_saturate_flag;
    logic acc_b_saturate_flag;
  } dsid_flags_s;
endpackage
`default_nettype wire

// *** core/dsid_field_dec.sv ***
// combinational operand field extraction for one instruction word
`default_nettype none
`include "dsid_regs.svh"
module dsid_field_dec #(
  parameter int WORD_W = 24
) (
  // instruction word and mode
  input  wire logic [WORD_W-1:0]   word,
  input  wire logic                byte_mode,
  // decoded fields
  output dsid_pkg::dsid_ops_s      ops,
  output dsid_pkg::dsid_dsp_s      dsp
);
  import dsid_pkg::*;

  // general fields: opcode on top, registers below
  always_comb
  begin
    ops                          = '0;
    ops.opcode                   = word[`DSID_OPC_MSB:`DSID_OPC_LSB]; // [RULE1]
    ops.base_reg_field           = word[14:11];                       // [RULE9]
    ops.source_reg_field         = word[3:0];                         // [RULE9]
    ops.dest_reg_field           = word[10:7];                        // [RULE9]
    ops.bit_select_field         = word[15:12];                       // [RULE10]
    ops.literal_ten_field        = word[13:4];
    // byte mode only admits the low 256 values
    ops.lit_ok                   = !byte_mode || (word[13:4] <= `DSID_LIT_BYTE_MAX); // [RULE11]
    ops.file_to_default_work_reg = !word[13];                         // [RULE8]
  end

  // dsp fields: register pair, prefetches and write-back
  always_comb
  begin
    dsp                    = '0;
    dsp.acc_sel            = word[15];                                // [RULE12]
    dsp.mul_a              = {2'h1, word[12:11]};
    dsp.mul_b              = {2'h1, word[10:9]};
    // pairs must be ascending (square when equal), always within W4..W7
    dsp.pair_ok            = (word[12:11] <= word[10:9]);             // [RULE13]
    dsp.x_prefetch_addr    = word[8:5];                               // [RULE14]
    dsp.x_dest             = word[4:3];
    dsp.y_prefetch_addr    = word[17:14];                             // [RULE15]
    dsp.y_dest             = word[2:1];
    dsp.acc_writeback_dest = {word[0], word[13]};                     // [RULE16]
  end
endmodule
`default_nettype wire

// *** core/dsid_flag_upd.sv ***
// status flag update for the add-class instructions
`default_nettype none
`include "dsid_regs.svh"
module dsid_flag_upd (
  // operands
  input  wire logic [15:0]         opa,
  input  wire logic [15:0]         opb,
  input  wire dsid_pkg::dsid_cls_e cls,
  input  wire logic                acc_sel,
  input  wire logic                acc_ovf,
  input  wire logic                acc_sat,
  input  wire dsid_pkg::dsid_flags_s cur,
  // results
  output logic [15:0]              sum,
  output dsid_pkg::dsid_flags_s    nxt
);
  import dsid_pkg::*;

  logic [16:0] full;
  logic [4:0]  nib;

  // carry-in only for add-with-carry
  always_comb
  begin
    full = {1'b0, opa} + {1'b0, opb} + {16'h0000, (cls == DSID_CLS_ADD_WITH_CARRY_OP) & cur.carry}; // [RULE18]
    nib  = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, (cls == DSID_CLS_ADD_WITH_CARRY_OP) & cur.carry};
    sum  = full[15:0];
    nxt  = cur;
    if (cls == DSID_CLS_ADD_WITH_CARRY_OP)
    begin
      // mcu flags only; dsp flags untouched
      nxt.carry            = full[16];                                   // [RULE18]
      nxt.digit_carry_flag = nib[4];
      nxt.negative         = full[15];
      nxt.overflow_flag    = (opa[15] == opb[15]) && (full[15] != opa[15]);
      nxt.zero             = (full[15:0] == 16'h0000);
    end
    else if (cls == DSID_CLS_ADDACC)
    begin
      // only the selected accumulator's overflow and saturate bits move
      if (acc_sel)
      begin
        nxt.acc_b_overflow_flag = acc_ovf;                               // [RULE17]
        nxt.acc_b_saturate_flag = acc_sat;
      end
      else
      begin
        nxt.acc_a_overflow_flag = acc_ovf;                               // [RULE17]
        nxt.acc_a_saturate_flag = acc_sat;
      end
    end
  end
endmodule
`default_nettype wire

// *** core/dsid_top.sv ***
// instruction decode and cycle timing for the signal controller core
// Function
// [RULE1] single word is 24 bits, 8-bit opcode
// [RULE2] three instruction types take two words
// [RULE3] lone second word executes as no-op
// [RULE4] double-word instructions take two cycles
// [RULE5] single word: one cycle, two if taken
// [RULE6] listed control instructions take two/three cycles
// [RULE7] skip costs two or three cycles
// [RULE8] file ops: address plus file-or-W0 destination
// [RULE9] register fields select W0 to W15
// [RULE10] bit select is four bits, 0..15
// [RULE11] ten-bit literal: byte 0..255, word 0..1023
// [RULE12] dsp ops name accumulator A or B
// [RULE13] multiply pairs restricted to W4..W7 ascending
// [RULE14] x prefetch via W8/W9, dest W4..W7
// [RULE15] y prefetch via W10/W11, dest W4..W7
// [RULE16] write-back to W13 or [W13]+=2
// [RULE17] accumulator add moves only its overflow/saturate bits
// [RULE18] add with carry updates five mcu flags
// [RULE19] extra cycles suppress write-back, never stall fetch
`default_nettype none
`include "dsid_regs.svh"
module dsid_top #(
  parameter int WORD_W = 24
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // fetch side
  input  wire logic                fetch_valid,
  input  wire logic [WORD_W-1:0]   fetch_word,
  input  wire dsid_pkg::dsid_cls_e fetch_cls,
  input  wire logic                byte_mode,
  input  wire logic                long_three,
  input  wire logic                cond_true,
  input  wire logic                next_is_double,
  // datapath side
  input  wire logic [15:0]         opa,
  input  wire logic [15:0]         opb,
  input  wire logic                acc_ovf,
  input  wire logic                acc_sat,
  // decoded outputs
  output dsid_pkg::dsid_ops_s      ops_r,
  output dsid_pkg::dsid_dsp_s      dsp_r,
  output dsid_pkg::dsid_flags_s    flags_r,
  output logic [15:0]              sum_r,
  output logic                     exec_en_r,
  output logic                     is_nop_r,
  output logic                     illegal_r,
  output logic [1:0]               cycles_r,
  output logic [15:0]              wb_step_r
);
  import dsid_pkg::*;

  dsid_ops_s   ops_c;
  dsid_dsp_s   dsp_c;
  dsid_flags_s flags_c;
  logic [15:0] sum_c;

  dsid_field_dec #(
    .WORD_W (WORD_W)
  ) u_dec (
    .word      (fetch_word),
    .byte_mode (byte_mode),
    .ops       (ops_c),
    .dsp       (dsp_c)
  );

  dsid_flag_upd u_flags (
    .opa     (opa),
    .opb     (opb),
    .cls     (fetch_cls),
    .acc_sel (dsp_c.acc_sel),
    .acc_ovf (acc_ovf),
    .acc_sat (acc_sat),
    .cur     (flags_r),
    .sum     (sum_c),
    .nxt     (flags_c)
  );

  dsid_state_e state_r;
  dsid_state_e state_nxt;
  logic [1:0]  nop_left_r;
  logic [1:0]  nop_left_nxt;
  dsid_ops_s   ops_nxt;
  dsid_dsp_s   dsp_nxt;
  dsid_flags_s flags_nxt;
  logic [15:0] sum_nxt;
  logic        exec_en_nxt;
  logic        is_nop_nxt;
  logic        illegal_nxt;
  logic [1:0]  cycles_nxt;
  logic [15:0] wb_step_nxt;
  logic        lone_second;

  // a word with zero opcode in run state is an orphan second word
  assign lone_second = (ops_c.opcode == `DSID_SECOND_OPC); // [RULE3]

  // sequencing: fetch never stalls, extra cycles just blank write-back
  always_comb
  begin
    state_nxt    = state_r;
    nop_left_nxt = nop_left_r;
    ops_nxt      = ops_r;
    dsp_nxt      = dsp_r;
    flags_nxt    = flags_r;
    sum_nxt      = sum_r;
    exec_en_nxt  = 1'b0;
    is_nop_nxt   = 1'b0;
    illegal_nxt  = 1'b0;
    cycles_nxt   = cycles_r;
    wb_step_nxt  = wb_step_r;
    if (fetch_valid)
    begin
      unique case (state_r)
        DSID_ST_RUN:
        begin
          ops_nxt     = ops_c;
          dsp_nxt     = dsp_c;
          wb_step_nxt = dsp_c.acc_writeback_dest[0] ? `DSID_WB_STEP : 16'h0000; // [RULE16]
          cycles_nxt  = `DSID_CYC_ONE;
          if (lone_second)
          begin
            is_nop_nxt = 1'b1; // [RULE3]
          end
          else
          begin
            exec_en_nxt = ops_c.lit_ok && !((fetch_cls == DSID_CLS_MAC) && !dsp_c.pair_ok);
            illegal_nxt = !exec_en_nxt;
            if (exec_en_nxt)
            begin
              flags_nxt = flags_c; // [RULE17] [RULE18]
              sum_nxt   = sum_c;
            end
            unique case (fetch_cls)
              DSID_CLS_DOUBLE:
              begin
                // second word is consumed as operand, not executed
                state_nxt  = DSID_ST_SEC; // [RULE2]
                cycles_nxt = `DSID_CYC_TWO; // [RULE4]
              end
              DSID_CLS_BRANCH:
              begin
                if (cond_true)
                begin
                  state_nxt    = DSID_ST_NOP; // [RULE5] [RULE19]
                  nop_left_nxt = `DSID_BLANK_ONE;
                  cycles_nxt   = `DSID_CYC_TWO;
                end
              end
              DSID_CLS_LONGSW:
              begin
                state_nxt    = DSID_ST_NOP; // [RULE6] [RULE19]
                nop_left_nxt = long_three ? `DSID_BLANK_TWO : `DSID_BLANK_ONE;
                cycles_nxt   = long_three ? `DSID_CYC_THREE : `DSID_CYC_TWO;
              end
              DSID_CLS_SKIP:
              begin
                if (cond_true)
                begin
                  state_nxt    = DSID_ST_NOP; // [RULE7] [RULE19]
                  nop_left_nxt = next_is_double ? `DSID_BLANK_TWO : `DSID_BLANK_ONE;
                  cycles_nxt   = next_is_double ? `DSID_CYC_THREE : `DSID_CYC_TWO;
                end
              end
              default:
              begin
                cycles_nxt = `DSID_CYC_ONE; // [RULE5]
              end
            endcase
          end
        end
        DSID_ST_SEC:
        begin
          // second cycle of a double-word instruction
          is_nop_nxt = 1'b0;
          state_nxt  = DSID_ST_RUN; // [RULE4]
        end
        DSID_ST_NOP:
        begin
          // already fetched word is discarded: write-back stays low
          is_nop_nxt   = 1'b1; // [RULE19]
          nop_left_nxt = nop_left_r - 2'h1;
          if (nop_left_r == 2'h1)
          begin
            state_nxt = DSID_ST_RUN;
          end
        end
      endcase
    end
  end

  // register stage
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r    <= DSID_ST_RUN;
      nop_left_r <= 2'h0;
      ops_r      <= '0;
      dsp_r      <= '0;
      flags_r    <= '0;
      sum_r      <= 16'h0000;
      exec_en_r  <= 1'b0;
      is_nop_r   <= 1'b0;
      illegal_r  <= 1'b0;
      cycles_r   <= 2'h0;
      wb_step_r  <= 16'h0000;
    end
    else
    begin
      state_r    <= state_nxt;
      nop_left_r <= nop_left_nxt;
      ops_r      <= ops_nxt;
      dsp_r      <= dsp_nxt;
      flags_r    <= flags_nxt;
      sum_r      <= sum_nxt;
      exec_en_r  <= exec_en_nxt;
      is_nop_r   <= is_nop_nxt;
      illegal_r  <= illegal_nxt;
      cycles_r   <= cycles_nxt;
      wb_step_r  <= wb_step_nxt;
    end
  end

  // taken branch then one blank cycle
  sequence s_branch_taken;
    fetch_valid && state_r == DSID_ST_RUN && fetch_cls == DSID_CLS_BRANCH && cond_true && !lone_second;
  endsequence

  sequence s_skip_double;
    fetch_valid && state_r == DSID_ST_RUN && fetch_cls == DSID_CLS_SKIP && cond_true && next_is_double
      && !lone_second;
  endsequence

  a_lone_second_nop: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE3]
    (fetch_valid && state_r == DSID_ST_RUN && lone_second) |=> (is_nop_r && !exec_en_r))
    else $error("lone second word did not execute as no-op");

  a_branch_blank: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE5]
    s_branch_taken ##1 fetch_valid |=> (is_nop_r && !exec_en_r))
    else $error("taken branch missing blank cycle");

  a_branch_cycles: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE5]
    s_branch_taken |=> (cycles_r == 2'h2))
    else $error("taken branch cycle count wrong");

  a_skip_double: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE7]
    s_skip_double ##1 fetch_valid [*2] |=> (is_nop_r && !exec_en_r) && $past(is_nop_r))
    else $error("double-word skip not three cycles");

  a_double_two: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE4]
    (fetch_valid && state_r == DSID_ST_RUN && fetch_cls == DSID_CLS_DOUBLE && !lone_second)
      |=> (state_r == DSID_ST_SEC && cycles_r == 2'h2))
    else $error("double-word instruction not two cycles");

  a_lit_byte: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE11]
    (fetch_valid && state_r == DSID_ST_RUN && !lone_second && byte_mode && fetch_word[13:4] > 10'h0FF)
      |=> (illegal_r && !exec_en_r))
    else $error("byte literal above 255 accepted");

  a_addacc_flags: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE17]
    (fetch_valid && state_r == DSID_ST_RUN && !lone_second && fetch_cls == DSID_CLS_ADDACC && ops_c.lit_ok)
      |=> (flags_r.carry == $past(flags_r.carry) && flags_r.zero == $past(flags_r.zero)))
    else $error("accumulator add changed mcu flags");

  a_add_with_carry_op_carry: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE18]
    (fetch_valid && state_r == DSID_ST_RUN && !lone_second && fetch_cls == DSID_CLS_ADD_WITH_CARRY_OP && ops_c.lit_ok)
      |=> (sum_r == 16'($past(opa) + $past(opb) + {15'h0000, $past(flags_r.carry)})))
    else $error("add with carry sum wrong");

  a_writeback_step: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE16]
    (fetch_valid && state_r == DSID_ST_RUN)
      |=> (wb_step_r == ($past(fetch_word[13]) ? `DSID_WB_STEP : 16'h0000)))
    else $error("write-back step does not follow the post-increment choice");

  // long control op: two blank cycles follow the issue cycle
  sequence s_long_three;
    fetch_valid && state_r == DSID_ST_RUN && fetch_cls == DSID_CLS_LONGSW && long_three && !lone_second;
  endsequence

  a_long_cycles: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE6]
    s_long_three |=> (cycles_r == `DSID_CYC_THREE))
    else $error("three-cycle control op reported wrong count");

  a_long_blank: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE6]
    s_long_three ##1 fetch_valid [*2]
      |=> (is_nop_r && !exec_en_r && $past(is_nop_r) && state_r == DSID_ST_RUN))
    else $error("three-cycle control op not followed by two blanks");

  // operand word of a double-word op is consumed, neither run nor blanked
  a_second_quiet: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE4]
    (fetch_valid && state_r == DSID_ST_SEC)
      |=> (!exec_en_r && !is_nop_r && !illegal_r && state_r == DSID_ST_RUN))
    else $error("second word of a double-word op was decoded");

  a_blank_write: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE19]
    (fetch_valid && state_r == DSID_ST_NOP) |=> (is_nop_r && !exec_en_r && !illegal_r))
    else $error("discarded word reached write-back");

  a_mac_pair: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE13]
    (fetch_valid && state_r == DSID_ST_RUN && !lone_second && fetch_cls == DSID_CLS_MAC
      && fetch_word[12:11] > fetch_word[10:9]) |=> (illegal_r && !exec_en_r))
    else $error("descending multiply pair accepted");

  a_add_with_carry_op_flags: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE18]
    (fetch_valid && state_r == DSID_ST_RUN && !lone_second && fetch_cls == DSID_CLS_ADD_WITH_CARRY_OP && ops_c.lit_ok)
      |=> (flags_r.zero == (sum_r == 16'h0000) && flags_r.negative == sum_r[15]))
    else $error("add with carry zero or negative flag wrong");
endmodule
`default_nettype wire

// *** tb/dsid_fetch_model.sv ***
// fetch unit and datapath model that feeds words and operands to the decoder
`default_nettype none
module dsid_fetch_model (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // request from the bench
  input  wire logic                go,
  input  wire logic [23:0]         word,
  input  wire dsid_pkg::dsid_cls_e cls,
  input  wire logic [3:0]          ctl,
  input  wire logic [15:0]         a,
  input  wire logic [15:0]         b,
  input  wire logic [1:0]          acc_res,
  // lines toward the decoder
  output logic                     fetch_valid,
  output logic [23:0]              fetch_word,
  output dsid_pkg::dsid_cls_e      fetch_cls,
  output logic                     byte_mode,
  output logic                     long_three,
  output logic                     cond_true,
  output logic                     next_is_double,
  output logic [15:0]              opa,
  output logic [15:0]              opb,
  output logic                     acc_ovf,
  output logic                     acc_sat
);
  timeunit 1ns;
  timeprecision 1ps;
  import dsid_pkg::*;

  // one word per cycle, never stalls; an idle word bus inverts on every idle cycle,
  // so it shows the inverse of the last word first and the word itself again one cycle later
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fetch_valid    <= 1'b0;
      fetch_word     <= 24'h000000;
      fetch_cls      <= DSID_CLS_PLAIN;
      {next_is_double, cond_true, long_three, byte_mode} <= 4'h0;
      {opa, opb, acc_ovf, acc_sat} <= 34'h0;
    end
    else if (go)
    begin
      fetch_valid    <= 1'b1;
      fetch_word     <= word;
      fetch_cls      <= cls;
      {next_is_double, cond_true, long_three, byte_mode} <= ctl;
      {opa, opb, acc_ovf, acc_sat} <= {a, b, acc_res};
    end
    else
    begin
      fetch_valid    <= 1'b0;
      fetch_word     <= ~fetch_word;
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the instruction decode and timing block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dsid_pkg::*;

  // expected {exec, nop, illegal, cycles}
  localparam logic [4:0] ex1 = 5'h11;
  localparam logic [4:0] ex2 = 5'h12;
  localparam logic [4:0] ex3 = 5'h13;
  localparam logic [4:0] nop = 5'h08;
  localparam logic [4:0] sec = 5'h00;
  localparam logic [4:0] ill = 5'h04;
  localparam logic [23:0] w1 = 24'h12FFFF;
  localparam logic [23:0] w0 = 24'h120000;

  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        go       = 1'b0;
  logic [23:0] word     = 24'h000000;
  dsid_cls_e   cls      = DSID_CLS_PLAIN;
  logic [3:0]  ctl      = 4'h0;
  logic [15:0] a        = 16'h0000;
  logic [15:0] b        = 16'h0000;
  logic [1:0]  acc_res  = 2'h0;
  logic        fetch_valid, byte_mode, long_three, cond_true, next_is_double, acc_ovf, acc_sat;
  logic [23:0] fetch_word;
  dsid_cls_e   fetch_cls;
  logic [15:0] opa, opb, sum_r, wb_step_r;
  dsid_ops_s   ops_r;
  dsid_dsp_s   dsp_r;
  dsid_flags_s flags_r;
  logic        exec_en_r, is_nop_r, illegal_r;
  logic [1:0]  cycles_r;
  logic [4:0]  obs_q[$];
  logic [4:0]  exp_q[$];
  int          err_total  = 0;
  int          num_checks = 0;
  int          cyc_cnt    = 0;

  always #10 core_clk = ~core_clk;

  dsid_fetch_model i_dsid_fetch_model (.core_clk(core_clk), .rst_n(rst_n), .go(go), .word(word), .cls(cls),
    .ctl(ctl), .a(a), .b(b), .acc_res(acc_res), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
    .fetch_cls(fetch_cls), .byte_mode(byte_mode), .long_three(long_three), .cond_true(cond_true),
    .next_is_double(next_is_double), .opa(opa), .opb(opb), .acc_ovf(acc_ovf), .acc_sat(acc_sat));

  dsid_top #(.WORD_W(24)) i_dsid_top (.core_clk(core_clk), .rst_n(rst_n), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_cls(fetch_cls), .byte_mode(byte_mode), .long_three(long_three),
    .cond_true(cond_true), .next_is_double(next_is_double), .opa(opa), .opb(opb), .acc_ovf(acc_ovf),
    .acc_sat(acc_sat), .ops_r(ops_r), .dsp_r(dsp_r), .flags_r(flags_r), .sum_r(sum_r),
    .exec_en_r(exec_en_r), .is_nop_r(is_nop_r), .illegal_r(illegal_r), .cycles_r(cycles_r),
    .wb_step_r(wb_step_r));

  // log the one-cycle pulses at every edge once they have settled
  always @(posedge core_clk)
  begin
    #1;
    obs_q.push_back({exec_en_r, is_nop_r, illegal_r, cycles_r});
  end

  // hang guard, well above the under a hundred cycles the tests need
  always @(posedge core_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 2000)
    begin
      err_total++;
      close_out();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic start_test();
    @(negedge core_clk);
    obs_q.delete();
    exp_q.delete();
  endtask

  // one word per call, calls run back to back with no gap
  task automatic step(input dsid_cls_e c, input logic [23:0] w, input logic [3:0] k, input logic [4:0] e,
                      input logic [15:0] x = 16'h0000, input logic [15:0] y = 16'h0000,
                      input logic [1:0] r = 2'h0);
    @(posedge core_clk);
    go      <= 1'b1;
    word    <= w;
    cls     <= c;
    ctl     <= k;
    a       <= x;
    b       <= y;
    acc_res <= r;
    exp_q.push_back(e);
  endtask

  // result of word n lands two edges after it was handed to the model
  task automatic end_test(input string name);
    @(posedge core_clk);
    go <= 1'b0;
    repeat (3) @(posedge core_clk);
    #2;
    foreach (exp_q[n])
    begin
      check(16'(obs_q[n + 2][4:2]), 16'(exp_q[n][4:2]));
      if (exp_q[n][4])
        check(16'(obs_q[n + 2][1:0]), 16'(exp_q[n][1:0]));
    end
    $display("test %s done", name);
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #2;
    check(16'({exec_en_r, is_nop_r, illegal_r, cycles_r}), 16'h0000);
    check(16'(flags_r), 16'h0000);
    // all-ones operand bits put every register field at its top value
    start_test();
    step(DSID_CLS_PLAIN, w1, 4'h0, ex1);
    end_test("plain");
    check(16'(ops_r.opcode), 16'h0012);
    check(16'({ops_r.source_reg_field, ops_r.dest_reg_field, ops_r.base_reg_field}), 16'h0FFF);
    check(16'(ops_r.bit_select_field), 16'h000F);
    start_test();
    step(DSID_CLS_PLAIN, 24'h000000, 4'h0, nop);
    step(DSID_CLS_BRANCH, w0, 4'h4, ex2);
    step(DSID_CLS_PLAIN, w0, 4'h0, nop);
    step(DSID_CLS_PLAIN, w0, 4'h0, ex1);
    step(DSID_CLS_BRANCH, w0, 4'h0, ex1);
    step(DSID_CLS_PLAIN, w0, 4'h0, ex1);
    end_test("branch");
    start_test();
    step(DSID_CLS_LONGSW, w0, 4'h2, ex3);
    step(DSID_CLS_PLAIN, w0, 4'h0, nop);
    step(DSID_CLS_PLAIN, w0, 4'h0, nop);
    step(DSID_CLS_LONGSW, w0, 4'h0, ex2);
    step(DSID_CLS_PLAIN, w0, 4'h0, nop);
    step(DSID_CLS_PLAIN, w0, 4'h0, ex1);
    end_test("long");
    start_test();
    step(DSID_CLS_SKIP, w0, 4'h4, ex2);
    step(DSID_CLS_PLAIN, w0, 4'h0, nop);
    step(DSID_CLS_SKIP, w0, 4'hC, ex3);
    step(DSID_CLS_PLAIN, w0, 4'h0, nop);
    step(DSID_CLS_PLAIN, w0, 4'h0, nop);
    step(DSID_CLS_SKIP, w0, 4'h0, ex1);
    step(DSID_CLS_PLAIN, w0, 4'h0, ex1);
    end_test("skip");
    start_test();
    step(DSID_CLS_DOUBLE, w0, 4'h0, ex2);
    step(DSID_CLS_PLAIN, 24'h000000, 4'h0, sec);
    step(DSID_CLS_DOUBLE, w1, 4'h0, ex2);
    step(DSID_CLS_PLAIN, 24'h00FFFF, 4'h0, sec);
    step(DSID_CLS_PLAIN, w0, 4'h0, ex1);
    end_test("double");
    // last word: descending pair, accumulator B, post-incremented write-back
    start_test();
    step(DSID_CLS_LIT, w1, 4'h1, ill);
    step(DSID_CLS_LIT, w1, 4'h0, ex1);
    step(DSID_CLS_LIT, w0, 4'h1, ex1);
    step(DSID_CLS_MAC, w1, 4'h0, ex1);
    step(DSID_CLS_FILEREG, w1, 4'h0, ex1);
    step(DSID_CLS_BIT, w1, 4'h0, ex1);
    step(DSID_CLS_MAC, 24'h12B800, 4'h0, ill);
    end_test("operand");
    check(16'(dsp_r.acc_sel), 16'h0001);
    check(16'({dsp_r.pair_ok, dsp_r.mul_a, dsp_r.mul_b}), 16'h0074);
    check(16'({dsp_r.y_prefetch_addr, dsp_r.x_prefetch_addr}), 16'h00A0);
    check(wb_step_r, 16'h0002);
    check(16'(ops_r.literal_ten_field), 16'h0380);
    check(16'({ops_r.lit_ok, ops_r.file_to_default_work_reg}), 16'h0002);
    // carry out of the first add must feed the second
    start_test();
    step(DSID_CLS_ADD_WITH_CARRY_OP, w0, 4'h0, ex1, 16'hFFFF, 16'h0002);
    end_test("addc1");
    check(sum_r, 16'h0001);
    check(16'(flags_r), 16'h0180);
    start_test();
    step(DSID_CLS_ADD_WITH_CARRY_OP, w0, 4'h0, ex1, 16'h7FFF, 16'h0000);
    end_test("addc2");
    check(sum_r, 16'h8000);
    check(16'(flags_r), 16'h00E0);
    start_test();
    step(DSID_CLS_ADDACC, w0, 4'h0, ex1, 16'h1234, 16'h4321, 2'h3);
    end_test("addacc");
    check(16'(flags_r[8:4]), 16'h000E);
    check(16'(flags_r[3:0]), 16'h000A);
    // second reset in mid-run clears the status image, then decoding resumes
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    #1;
    check(16'(flags_r), 16'h0000);
    @(posedge core_clk);
    rst_n <= 1'b1;
    start_test();
    step(DSID_CLS_BRANCH, w0, 4'h4, ex2);
    step(DSID_CLS_PLAIN, w0, 4'h0, nop);
    step(DSID_CLS_PLAIN, w0, 4'h0, ex1);
    end_test("reset");
    close_out();
  end
endmodule
`default_nettype wire
